// ---- hdl/dac_ctrl_pkg.sv ----
// Constants and carriers for the DAC mode-control block.
// Assumes a single clock domain; the command word arrives already framed.
package dac_ctrl_pkg;

  // ----------------------------------------------------------------
  // Channel layout
  // ----------------------------------------------------------------
  localparam int NUM_CH = 8; // Analog outputs
  localparam int LO_CH = 6; // Channels in the low mute/disable registers
  localparam int HI_CH = NUM_CH - LO_CH; // Channels in the high registers

  // ----------------------------------------------------------------
  // Control word layout
  // ----------------------------------------------------------------
  localparam int CW_RW_BIT = 15; // 1 = read, 0 = write
  localparam int CW_IDX_MSB = 14;
  localparam int CW_IDX_LSB = 8;
  localparam int CW_DAT_MSB = 7;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [NUM_CH-1:0][6:0] IDX_ATTEN = {
    7'h11, 7'h10, 7'h06, 7'h05, 7'h04, 7'h03, 7'h02, 7'h01};
  localparam logic [6:0] IDX_MUTE_LO = 7'h07;
  localparam logic [6:0] IDX_DIS_LO = 7'h08;
  localparam logic [6:0] IDX_FCF = 7'h09;
  localparam logic [6:0] IDX_ZFE = 7'h0A;
  localparam logic [6:0] IDX_MUTE_HI = 7'h12;
  localparam logic [6:0] IDX_DIS_HI = 7'h13;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int FCF_ROLLOFF_BIT = 5;
  localparam int FCF_HALF_BIT = 4;
  localparam int FCF_CKDIS_BIT = 3;
  localparam int FCF_FMT_LSB = 0;
  localparam int ZFE_POL_BIT = 6;
  localparam int ZFE_PHASE_BIT = 5;
  localparam int ZFE_RATE_LSB = 3;
  localparam int ZFE_EMPH_LSB = 0;
  localparam logic [7:0] ATTEN_RESET = 8'hFF; // 0 dB
  localparam logic [7:0] ATTEN_MUTE = 8'h80; // Highest infinite code
  localparam int ZERO_RUN_DEF = 1024; // Sample periods of zero data
  localparam int STEP_FS_DEF = 8; // Sample periods per ramp step

  // ----------------------------------------------------------------
  // Audio formats
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FMT_RJ24 = 3'h0,
    FMT_RJ20 = 3'h1,
    FMT_RJ18 = 3'h2,
    FMT_RJ16 = 3'h3,
    FMT_I2S = 3'h4,
    FMT_LJ = 3'h5
  } audio_format_select_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid; // One-cycle strobe
    logic [15:0] word; // Framed control word
  } ctrl_cmd_t;

  typedef struct packed {
    logic valid; // One-cycle strobe
    logic [15:0] word; // Read answer
  } ctrl_resp_t;

endpackage : dac_ctrl_pkg

// ---- hdl/dac_mode_control.sv ----
// DAC mode control: register file, attenuation ramp with soft mute,
// zero detect, clock output select and the static mode outputs.
// Assumes framed control words and a sample-rate tick from logic on mclk_in.
//
// Summary of operation
// - Eight readable 8-bit attenuation levels, reset 0xFF
// - Codes above 128: half-dB steps below 255
// - Codes 0 to 128 mean full mute
// - Step level once per eight sample periods
// - Soft mute ramps level down to mute
// - Clearing mute ramps back to programmed level
// - Disable bit switches output to common mode
// - Rolloff bit: 0 sharp, 1 slow
// - Half-rate bit halves the clock output
// - Clock output disable holds pin low
// - Three-bit format decode, 110/111 not written
// - Zero-flag polarity bit inverts flag pins
// - Top word bit selects read or write
// - All control fields read back their value
// - Any of three emphasis bits enables emphasis
// - Zero detect after 1024 zero sample periods
// - Seven-bit index routes the eight data bits
`timescale 1ns/1ps
module dac_mode_control #(
  parameter int ZERO_RUN_LEN = dac_ctrl_pkg::ZERO_RUN_DEF,
  parameter int STEP_FS_PERIODS = dac_ctrl_pkg::STEP_FS_DEF
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire dac_ctrl_pkg::ctrl_cmd_t cmd_in,
  output dac_ctrl_pkg::ctrl_resp_t resp_out,
  input wire logic fs_tick_in,
  input wire logic [dac_ctrl_pkg::NUM_CH-1:0] sample_zero_in,
  output logic [dac_ctrl_pkg::NUM_CH-1:0][7:0] channel_atten_level_out,
  output logic [dac_ctrl_pkg::NUM_CH-1:0] channel_muted_out,
  output logic [dac_ctrl_pkg::NUM_CH-1:0] channel_output_disable_out,
  output logic filter_rolloff_select_out,
  output dac_ctrl_pkg::audio_format_select_t audio_format_select_out,
  output logic emphasis_all_enable_out,
  output logic [1:0] emphasis_rate_select_out,
  output logic output_phase_invert_out,
  output logic [dac_ctrl_pkg::NUM_CH-1:0] zero_flag_out,
  output logic zero_flag_all_out,
  output logic system_clock_output_out
);
  import dac_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int ZW = $clog2(ZERO_RUN_LEN + 1); // Zero-run counter width
  localparam int SW = $clog2(STEP_FS_PERIODS + 1); // Step divider width
  localparam logic [ZW-1:0] ZERO_FULL = ZW'(ZERO_RUN_LEN);
  localparam logic [ZW-1:0] ZERO_ONE_SHORT = ZW'(ZERO_RUN_LEN - 1); // Last count before detect
  localparam logic [SW-1:0] STEP_LAST = SW'(STEP_FS_PERIODS - 1);

  typedef struct packed {
    logic [NUM_CH-1:0][7:0] atten; // Programmed levels
    logic [NUM_CH-1:0] mute; // Soft mute requests
    logic [NUM_CH-1:0] dis; // Output disables
    logic filter_rolloff_select; // Rolloff select
    logic clock_out_half_rate; // Clock output half rate
    logic clock_out_disable; // Clock output disable
    logic [2:0] fmt; // Audio format
    logic zero_flag_polarity; // Zero-flag polarity
    logic output_phase_invert; // Output phase invert, stored only
    logic [1:0] dmf; // Emphasis rate
    logic [2:0] emphasis_all_enable; // Emphasis enables, ORed
    logic [NUM_CH-1:0][7:0] level; // Applied levels
    logic [SW-1:0] fs_cnt; // Sample periods since last step
    logic [NUM_CH-1:0][ZW-1:0] zcnt; // Zero-run counters
    logic clk_half; // Divided clock
    ctrl_resp_t resp; // Read answer
  } state_t;

  state_t state_reg; // Registered state
  state_t state_next; // Next state
  logic step; // Ramp step this cycle
  logic is_wr; // Write request
  logic is_rd; // Read request
  logic [6:0] idx; // Addressed register
  logic [7:0] wdat; // Write data
  logic [7:0] rdat; // Read data
  logic [7:0] tgt; // Per-channel ramp target

  assign idx = cmd_in.word[CW_IDX_MSB:CW_IDX_LSB];
  assign wdat = cmd_in.word[CW_DAT_MSB:0];
  assign is_wr = cmd_in.valid && !cmd_in.word[CW_RW_BIT];
  assign is_rd = cmd_in.valid && cmd_in.word[CW_RW_BIT];
  assign step = fs_tick_in && (state_reg.fs_cnt == STEP_LAST);

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Reserved bits and unused indices read as zero
  always_comb begin
    rdat = 8'h00;
    for (int c = 0; c < NUM_CH; c++) begin
      if (idx == IDX_ATTEN[c]) begin
        rdat = state_reg.atten[c];
      end
    end
    unique case (idx)
      IDX_MUTE_LO: rdat[LO_CH-1:0] = state_reg.mute[LO_CH-1:0];
      IDX_MUTE_HI: rdat[HI_CH-1:0] = state_reg.mute[NUM_CH-1:LO_CH];
      IDX_DIS_LO: rdat[LO_CH-1:0] = state_reg.dis[LO_CH-1:0];
      IDX_DIS_HI: rdat[HI_CH-1:0] = state_reg.dis[NUM_CH-1:LO_CH];
      IDX_FCF: begin
        rdat[FCF_ROLLOFF_BIT] = state_reg.filter_rolloff_select;
        rdat[FCF_HALF_BIT] = state_reg.clock_out_half_rate;
        rdat[FCF_CKDIS_BIT] = state_reg.clock_out_disable;
        rdat[FCF_FMT_LSB+:3] = state_reg.fmt;
      end
      IDX_ZFE: begin
        rdat[ZFE_POL_BIT] = state_reg.zero_flag_polarity;
        rdat[ZFE_PHASE_BIT] = state_reg.output_phase_invert;
        rdat[ZFE_RATE_LSB+:2] = state_reg.dmf;
        rdat[ZFE_EMPH_LSB+:3] = state_reg.emphasis_all_enable;
      end
      default: begin
        // Attenuation and unmapped indices handled above
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    tgt = ATTEN_MUTE;
    state_next = state_reg;
    state_next.resp.valid = 1'b0;
    state_next.clk_half = !state_reg.clk_half;
    // Register writes; reserved bits are simply not stored
    if (is_wr) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (idx == IDX_ATTEN[c]) begin
          state_next.atten[c] = wdat;
        end
      end
      unique case (idx)
        IDX_MUTE_LO: state_next.mute[LO_CH-1:0] = wdat[LO_CH-1:0];
        IDX_MUTE_HI: state_next.mute[NUM_CH-1:LO_CH] = wdat[HI_CH-1:0];
        IDX_DIS_LO: state_next.dis[LO_CH-1:0] = wdat[LO_CH-1:0];
        IDX_DIS_HI: state_next.dis[NUM_CH-1:LO_CH] = wdat[HI_CH-1:0];
        IDX_FCF: begin
          state_next.filter_rolloff_select = wdat[FCF_ROLLOFF_BIT];
          state_next.clock_out_half_rate = wdat[FCF_HALF_BIT];
          state_next.clock_out_disable = wdat[FCF_CKDIS_BIT];
          state_next.fmt = wdat[FCF_FMT_LSB+:3];
        end
        IDX_ZFE: begin
          state_next.zero_flag_polarity = wdat[ZFE_POL_BIT];
          state_next.output_phase_invert = wdat[ZFE_PHASE_BIT];
          state_next.dmf = wdat[ZFE_RATE_LSB+:2];
          state_next.emphasis_all_enable = wdat[ZFE_EMPH_LSB+:3];
        end
        default: begin
          // Writes to other indices are dropped
        end
      endcase
    end
    // Read answer one cycle after the request
    if (is_rd) begin
      state_next.resp.valid = 1'b1;
      state_next.resp.word = {1'b1, idx, rdat};
    end
    // Step divider counts sample periods
    if (fs_tick_in) begin
      state_next.fs_cnt = step ? '0 : SW'(state_reg.fs_cnt + 1'b1);
    end
    for (int c = 0; c < NUM_CH; c++) begin
      // Codes at or below the mute code all collapse onto it
      tgt = state_reg.atten[c] < ATTEN_MUTE ? ATTEN_MUTE : state_reg.atten[c];
      if (state_reg.mute[c]) begin
        tgt = ATTEN_MUTE;
      end
      // Ramp from where we are; a new target only turns the direction
      if (step && state_reg.level[c] < tgt) begin
        state_next.level[c] = state_reg.level[c] + 8'h01;
      end else if (step && state_reg.level[c] > tgt) begin
        state_next.level[c] = state_reg.level[c] - 8'h01;
      end
      // Zero run counts sample periods and saturates
      if (fs_tick_in) begin
        if (!sample_zero_in[c]) begin
          state_next.zcnt[c] = '0;
        end else if (state_reg.zcnt[c] != ZERO_FULL) begin
          state_next.zcnt[c] = ZW'(state_reg.zcnt[c] + 1'b1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg <= '0;
      state_reg.atten <= {NUM_CH{ATTEN_RESET}};
      state_reg.level <= {NUM_CH{ATTEN_RESET}};
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] zdet; // Zero detect per channel
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      zdet[c] = state_reg.zcnt[c] == ZERO_FULL;
      channel_muted_out[c] = state_reg.level[c] <= ATTEN_MUTE;
    end
  end

  assign resp_out = state_reg.resp;
  assign channel_atten_level_out = state_reg.level;
  assign channel_output_disable_out = state_reg.dis;
  assign filter_rolloff_select_out = state_reg.filter_rolloff_select;
  assign audio_format_select_out = audio_format_select_t'(state_reg.fmt);
  assign emphasis_all_enable_out = |state_reg.emphasis_all_enable;
  assign emphasis_rate_select_out = state_reg.dmf;
  assign output_phase_invert_out = state_reg.output_phase_invert;
  assign zero_flag_out = state_reg.zero_flag_polarity ? ~zdet : zdet;
  assign zero_flag_all_out = state_reg.zero_flag_polarity ? ~(&zdet) : &zdet;
  // Full rate passes the clock itself; a flop cannot run at mclk rate.
  // The mux may glitch when the mode bits change, so switch when idle.
  assign system_clock_output_out = state_reg.clock_out_disable ? 1'b0 :
    (state_reg.clock_out_half_rate ? state_reg.clk_half : mclk_in);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_wr_att0;
    is_wr && idx == IDX_ATTEN[0];
  endsequence
  sequence s_rd_att0;
    is_rd && idx == IDX_ATTEN[0];
  endsequence

  // The host leaves one idle cycle between words, so the read follows two later
  property p_att_readback;
    s_wr_att0 ##2 s_rd_att0 |=>
      resp_out.valid && resp_out.word[7:0] == $past(cmd_in.word[7:0], 3);
  endproperty
  a_att_readback: assert property (p_att_readback)
    else $error("attenuation read-back mismatch");

  property p_floor;
    channel_atten_level_out[0] >= ATTEN_MUTE;
  endproperty
  a_floor: assert property (p_floor)
    else $error("applied level below mute code");

  property p_step_only;
    $changed(channel_atten_level_out[0]) |-> $past(step) &&
      (channel_atten_level_out[0] == $past(channel_atten_level_out[0]) + 8'h01 ||
       channel_atten_level_out[0] == $past(channel_atten_level_out[0]) - 8'h01);
  endproperty
  a_step_only: assert property (p_step_only)
    else $error("level moved off a step or by more than one");

  property p_mute_down;
    step && state_reg.mute[0] && state_reg.level[0] > ATTEN_MUTE |=>
      channel_atten_level_out[0] == $past(channel_atten_level_out[0]) - 8'h01;
  endproperty
  a_mute_down: assert property (p_mute_down)
    else $error("soft mute did not step down");

  property p_unmute_up;
    step && !state_reg.mute[0] && state_reg.level[0] < state_reg.atten[0] |=>
      channel_atten_level_out[0] == $past(channel_atten_level_out[0]) + 8'h01;
  endproperty
  a_unmute_up: assert property (p_unmute_up)
    else $error("release from mute did not step up");

  property p_dis_write;
    is_wr && idx == IDX_DIS_LO |=>
      channel_output_disable_out[LO_CH-1:0] == $past(wdat[LO_CH-1:0]);
  endproperty
  a_dis_write: assert property (p_dis_write)
    else $error("output disable not taken");

  property p_fcf_write;
    is_wr && idx == IDX_FCF |=> filter_rolloff_select_out == $past(wdat[FCF_ROLLOFF_BIT]) &&
      audio_format_select_out == $past(wdat[FCF_FMT_LSB+:3]);
  endproperty
  a_fcf_write: assert property (p_fcf_write)
    else $error("filter or format field not taken");

  property p_clk_off;
    state_reg.clock_out_disable |-> !system_clock_output_out;
  endproperty
  a_clk_off: assert property (p_clk_off)
    else $error("clock output not held low");

  property p_emph;
    is_wr && idx == IDX_ZFE && wdat[ZFE_EMPH_LSB+:3] != 3'h0 |=> emphasis_all_enable_out;
  endproperty
  a_emph: assert property (p_emph)
    else $error("emphasis not enabled by any bit");

  property p_zero_clear;
    fs_tick_in && !sample_zero_in[0] |=> zero_flag_out[0] == state_reg.zero_flag_polarity;
  endproperty
  a_zero_clear: assert property (p_zero_clear)
    else $error("zero flag held after nonzero sample");

  property p_read_answer;
    is_rd |=> resp_out.valid ##1 !resp_out.valid || $past(is_rd);
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer missing or stretched");

  property p_no_write_answer;
    !is_rd |=> !resp_out.valid;
  endproperty
  a_no_write_answer: assert property (p_no_write_answer)
    else $error("answer without a read");

  // Soft mute parks at the mute code and stays there
  property p_mute_floor;
    state_reg.mute[0] && state_reg.level[0] == ATTEN_MUTE |=>
      channel_atten_level_out[0] == ATTEN_MUTE;
  endproperty
  a_mute_floor: assert property (p_mute_floor)
    else $error("muted level left the mute code");

  // High-channel disables land in the top two outputs
  property p_dis_hi_write;
    is_wr && idx == IDX_DIS_HI |=>
      channel_output_disable_out[NUM_CH-1:LO_CH] == $past(wdat[HI_CH-1:0]);
  endproperty
  a_dis_hi_write: assert property (p_dis_hi_write)
    else $error("high output disable not taken");

  // Half rate: the divided clock flips at every rising edge
  property p_half_toggle;
    state_reg.clock_out_half_rate && !state_reg.clock_out_disable && $past(state_reg.clock_out_half_rate) && !$past(state_reg.clock_out_disable) |->
      $changed(system_clock_output_out);
  endproperty
  a_half_toggle: assert property (p_half_toggle)
    else $error("half-rate clock output did not toggle");

  // The tick that completes the zero run raises the flag
  property p_zero_set;
    fs_tick_in && sample_zero_in[0] && state_reg.zcnt[0] == ZERO_ONE_SHORT |=>
      zero_flag_out[0] == !state_reg.zero_flag_polarity;
  endproperty
  a_zero_set: assert property (p_zero_set)
    else $error("zero flag not raised after a full run");

endmodule : dac_mode_control

// ---- tb/host_ctrl_model.sv ----
// Host controller model driving framed control words into the block.
// Assumes one clock with the block; requests change just after rising edges.
`timescale 1ns/1ps
module host_ctrl_model (
  input wire logic mclk_in,
  output dac_ctrl_pkg::ctrl_cmd_t cmd_out,
  input wire dac_ctrl_pkg::ctrl_resp_t resp_in
);
  import dac_ctrl_pkg::*;
  // ----------------------------------------------------------------
  // Request pacing
  // ----------------------------------------------------------------
  int gap_cycles = 0; // Idle cycles before each request, for slow hosts
  initial cmd_out = '0;

  task automatic idle_gap();
    repeat (gap_cycles) @(posedge mclk_in);
  endtask : idle_gap

  // Write word; callers keep reserved bits and formats 110/111 out
  task automatic write_reg(input logic [6:0] idx, input logic [7:0] data);
    idle_gap();
    @(posedge mclk_in);
    cmd_out <= '{valid: 1'b1, word: {1'b0, idx, data}};
    @(posedge mclk_in);
    // Released word shows garbage, not the last value
    cmd_out <= '{valid: 1'b0, word: {1'b1, ~idx, ~data}};
  endtask : write_reg

  // Read word; answer awaited for a bounded two edges
  task automatic read_reg(input logic [6:0] idx, output logic [15:0] word);
    logic got;
    got = 1'b0;
    word = 'x;
    idle_gap();
    @(posedge mclk_in);
    cmd_out <= '{valid: 1'b1, word: {1'b1, idx, 8'h00}};
    @(posedge mclk_in);
    cmd_out <= '{valid: 1'b0, word: {1'b0, ~idx, 8'hFF}};
    repeat (2) begin
      @(posedge mclk_in);
      if (!got && resp_in.valid === 1'b1) begin
        word = resp_in.word;
        got = 1'b1;
      end
    end
  endtask : read_reg
endmodule : host_ctrl_model

// ---- tb/test_dac_mode_control.sv ----
// Self-checking bench for the DAC mode-control block.
// Assumes the host model above; ramp and zero counts shortened by parameters.
`timescale 1ns/1ps
module test_dac_mode_control;
  import dac_ctrl_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int ZRUN = 4; // Short zero run keeps the test quick
  localparam int STEP = 2; // Ticks per ramp step
  localparam logic [5:0][6:0] CTRL_IDX = {IDX_MUTE_LO, IDX_DIS_LO, IDX_FCF, IDX_ZFE,
    IDX_MUTE_HI, IDX_DIS_HI};
  logic mclk_in;
  logic rst_in;
  ctrl_cmd_t cmd;
  ctrl_resp_t resp;
  logic fs_tick;
  logic [NUM_CH-1:0] zero_in;
  logic [NUM_CH-1:0][7:0] level;
  logic [NUM_CH-1:0] muted, dis, zflag;
  logic rolloff, emph, phase, zall, sck, a1, b1, a2, b2;
  audio_format_select_t fmt;
  logic [1:0] rate;
  int err_total = 0;
  int total_checks = 0;

  dac_mode_control #(.ZERO_RUN_LEN(ZRUN), .STEP_FS_PERIODS(STEP)) uut (
    .mclk_in(mclk_in), .rst_in(rst_in), .cmd_in(cmd), .resp_out(resp),
    .fs_tick_in(fs_tick), .sample_zero_in(zero_in), .channel_atten_level_out(level),
    .channel_muted_out(muted), .channel_output_disable_out(dis),
    .filter_rolloff_select_out(rolloff), .audio_format_select_out(fmt),
    .emphasis_all_enable_out(emph), .emphasis_rate_select_out(rate),
    .output_phase_invert_out(phase), .zero_flag_out(zflag), .zero_flag_all_out(zall),
    .system_clock_output_out(sck));
  host_ctrl_model host (.mclk_in(mclk_in), .cmd_out(cmd), .resp_in(resp));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    host.write_reg(idx, d);
  endtask : wr

  // Read and compare the whole answer word
  task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
    logic [15:0] w;
    host.read_reg(idx, w);
    check(w, {1'b1, idx, exp});
  endtask : rd

  task automatic lv(input int ch, input logic [7:0] exp);
    check(16'(level[ch]), 16'(exp));
  endtask : lv

  // Sample-rate ticks two cycles apart, one spare cycle to settle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      fs_tick <= 1'b1;
      @(posedge mclk_in);
      fs_tick <= 1'b0;
    end
    @(posedge mclk_in);
    #1;
  endtask : ticks

  // Clock pin just after the rising and the falling edge
  task automatic probe(output logic a, output logic b);
    @(posedge mclk_in);
    #2 a = sck;
    @(negedge mclk_in);
    #2 b = sck;
  endtask : probe

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // Hang guard, far beyond the expected run of under 1500 cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    fs_tick = 1'b0;
    zero_in = '0;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    #1;
    // Reset defaults at pins and registers
    for (int i = 0; i < NUM_CH; i++) lv(i, 8'hFF);
    check({dis, rolloff, fmt, emph, rate, phase}, 16'h0000);
    check(16'({zflag, zall}), 16'h0000);
    for (int i = 0; i < NUM_CH; i++) rd(IDX_ATTEN[i], 8'hFF);
    for (int i = 0; i < 6; i++) rd(CTRL_IDX[i], 8'h00);
    rd(7'h20, 8'h00);
    // Distinct values prove index routing
    for (int i = 0; i < NUM_CH; i++) wr(IDX_ATTEN[i], 8'hF0 + 8'(i));
    for (int i = 0; i < NUM_CH; i++) rd(IDX_ATTEN[i], 8'hF0 + 8'(i));
    for (int i = 0; i < NUM_CH; i++) wr(IDX_ATTEN[i], 8'hFF);
    wr(IDX_MUTE_LO, 8'h2A);
    wr(IDX_MUTE_HI, 8'h01);
    rd(IDX_MUTE_LO, 8'h2A);
    rd(IDX_MUTE_HI, 8'h01);
    wr(IDX_MUTE_LO, 8'h00);
    wr(IDX_MUTE_HI, 8'h00);
    wr(IDX_DIS_LO, 8'h15);
    wr(IDX_DIS_HI, 8'h02);
    #1 check(16'(dis), 16'h0095);
    rd(IDX_DIS_HI, 8'h02);
    // Slow host for the mode fields
    host.gap_cycles = 3;
    for (int f = 0; f < 6; f++) begin
      wr(IDX_FCF, 8'(f) | (f[0] ? 8'h20 : 8'h00));
      #1 check(16'({rolloff, fmt}), 16'({f[0], 3'(f)}));
      rd(IDX_FCF, 8'(f) | (f[0] ? 8'h20 : 8'h00));
    end
    for (int v = 0; v < 8; v++) begin
      wr(IDX_ZFE, {2'b00, v[0], v[2], v[1], 3'(v)});
      #1 check(16'({emph, rate, phase}), 16'({v[2:0] != 3'h0, v[2], v[1], v[0]}));
      rd(IDX_ZFE, {2'b00, v[0], v[2], v[1], 3'(v)});
    end
    host.gap_cycles = 0;
    wr(IDX_ZFE, 8'h00);
    // Clock output: full rate, half rate, held low
    wr(IDX_FCF, 8'h00);
    probe(a1, b1);
    check(16'({a1, b1}), 16'h0002);
    wr(IDX_FCF, 8'h10);
    probe(a1, b1);
    probe(a2, b2);
    check(16'({a1 ^ b1, a2 ^ b2, a1 ^ a2}), 16'h0001);
    wr(IDX_FCF, 8'h18);
    probe(a1, b1);
    probe(a2, b2);
    check(16'({a1, b1, a2, b2}), 16'h0000);
    wr(IDX_FCF, 8'h00);
    // Ramp one step per STEP ticks, never a jump
    wr(IDX_ATTEN[0], 8'hFD);
    rd(IDX_ATTEN[0], 8'hFD);
    #1 lv(0, 8'hFF);
    ticks(STEP);
    lv(0, 8'hFE);
    ticks(STEP);
    lv(0, 8'hFD);
    ticks(STEP);
    lv(0, 8'hFD);
    // Target changed in mid-ramp
    wr(IDX_ATTEN[3], 8'h81);
    ticks(2 * STEP);
    lv(3, 8'hFD);
    wr(IDX_ATTEN[3], 8'hFF);
    ticks(STEP);
    lv(3, 8'hFE);
    // Soft mute on ch0, infinite code on ch2
    wr(IDX_MUTE_LO, 8'h01);
    wr(IDX_ATTEN[2], 8'h10);
    ticks(124 * STEP);
    lv(0, 8'h81);
    check(16'(muted[0]), 16'h0000);
    ticks(3 * STEP);
    lv(0, 8'h80);
    lv(2, 8'h80);
    check(16'({muted[2], muted[0]}), 16'h0003);
    rd(IDX_ATTEN[0], 8'hFD);
    wr(IDX_MUTE_LO, 8'h00);
    ticks(3 * STEP);
    lv(0, 8'h83);
    ticks(123 * STEP);
    lv(0, 8'hFD);
    // Zero detect at exactly ZRUN ticks, then polarity and independence
    @(posedge mclk_in);
    zero_in <= 8'hFF;
    ticks(ZRUN - 1);
    check(16'({zflag, zall}), 16'h0000);
    ticks(1);
    check(16'({zflag, zall}), 16'h01FF);
    wr(IDX_ZFE, 8'h40);
    #1 check(16'({zflag, zall}), 16'h0000);
    @(posedge mclk_in);
    zero_in <= 8'hFE;
    ticks(1);
    check(16'({zflag, zall}), 16'h0003);
    end_of_test();
  end
endmodule : test_dac_mode_control
